//--- bench/tfp_media_model.sv
// Purpose: Media engine stand-in facing the task-file port.
// Assumes: One command at a time; write commands take one data word.
// Notes: The bench sets the latency and the failure code.
`default_nettype none
module tfp_media_model
    import tfp_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Task-file side.
    input wire logic [7:0] cmd_code,
    input wire logic cmd_start,
    input wire logic host_wvalid,
    output var tfp_pkg::tfp_engine_t engine,
    output logic [15:0] engine_rdata,
    output logic engine_rvalid,
    // Bench control.
    input wire logic [7:0] latency,
    input wire logic fail_mode,
    input wire logic [7:0] fail_code
);
    logic [7:0] wait_q;
    logic busy_q;
    always_ff @(posedge clock)
    begin
        engine.done <= 1'b0;
        engine_rvalid <= 1'b0;
        engine_rdata <= ~engine_rdata;
        if (reset)
        begin
            busy_q <= 1'b0;
            engine <= '0;
            engine_rdata <= 16'h5A5A;
        end
        else if (cmd_start)
        begin
            busy_q <= 1'b1;
            wait_q <= latency;
            engine.xfer <= cmd_code[7:4] == 4'h3 || cmd_code == 8'hC5 || cmd_code == 8'hCD;
        end
        else if (busy_q && engine.xfer)
        begin
            if (host_wvalid)
                engine.xfer <= 1'b0;
        end
        else if (busy_q && wait_q == 8'h00)
        begin
            busy_q <= 1'b0;
            engine.done <= 1'b1;
            engine.fail <= fail_mode;
            engine.fault <= fail_mode ? fail_code : 8'h00;
        end
        else if (busy_q)
            wait_q <= wait_q - 8'h01;
    end
endmodule // tfp_media_model
`default_nettype wire

//--- bench/tfp_task_file_tb.sv
// Purpose: Self-checking bench for the task-file port.
// Assumes: Card is unit 0; word accesses only.
// Notes: Busy is polled through alternate status.
`default_nettype none
module tfp_task_file_tb;
    import tfp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, reset, data_oe, card_interrupt_request_n, cmd_start, engine_rvalid;
    logic host_wvalid, host_rtaken, soft_reset, fail_mode;
    tfp_bus_t bus;
    tfp_engine_t engine;
    logic [15:0] data_in, data_out, engine_rdata, host_wdata, last_w;
    logic [7:0] cmd_code, cmd_option, latency, fail_code, rd;
    logic [8:0] cmd_sectors;
    logic [27:0] cmd_lba;
    logic [7:0] codes [27] = '{8'hE5, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'hE6, 8'h99, 8'hE2,
        8'h96, 8'hE0, 8'h94, 8'h20, 8'h21, 8'hC4, 8'h22, 8'h23, 8'h40, 8'h41, 8'h30, 8'h31,
        8'hC5, 8'h38, 8'hCD, 8'h32, 8'h33, 8'h3C};
    int fail_count = 0;
    int total_checks = 0;
    int starts = 0;
    tfp_task_file u_tfp_task_file (.clock(clock), .reset(reset), .bus(bus), .byte_mode(1'b0),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .card_interrupt_request_n(card_interrupt_request_n), .unit_number_config(1'b0),
        .engine(engine), .engine_rdata(engine_rdata), .engine_rvalid(engine_rvalid),
        .cmd_code(cmd_code), .cmd_start(cmd_start), .cmd_sectors(cmd_sectors),
        .cmd_lba(cmd_lba), .cmd_option(cmd_option), .host_wdata(host_wdata),
        .host_wvalid(host_wvalid), .host_rtaken(host_rtaken), .soft_reset(soft_reset));
    tfp_media_model u_tfp_media_model (.clock(clock), .reset(reset), .cmd_code(cmd_code),
        .cmd_start(cmd_start), .host_wvalid(host_wvalid), .engine(engine),
        .engine_rdata(engine_rdata), .engine_rvalid(engine_rvalid), .latency(latency),
        .fail_mode(fail_mode), .fail_code(fail_code));
    always @(posedge clock)
    begin
        if (cmd_start === 1'b1)
            starts <= starts + 1;
        if (host_wvalid === 1'b1)
            last_w <= host_wdata;
    end
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic sec, input logic [2:0] a, input logic w, input logic [15:0] d);
        @(posedge clock);
        bus <= '{primary_select_n: sec, secondary_select_n: !sec, addr: a,
            io_read_strobe_n: w, io_write_strobe_n: !w};
        data_in <= d;
        @(posedge clock);
        @(negedge clock);
        rd = data_out[7:0];
        @(posedge clock);
        bus.io_read_strobe_n <= 1'b1;
        bus.io_write_strobe_n <= 1'b1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        acc(1'b0, a, 1'b1, {8'h00, d});
    endtask
    task automatic rdr(input logic [2:0] a);
        acc(1'b0, a, 1'b0, 16'h0000);
    endtask
    task automatic idle_wait();
        for (int k = 0; k < 300; k++)
        begin
            acc(1'b1, OFS_SHADOW, 1'b0, 16'h0000);
            if (rd[BIT_DRQ] === 1'b1)
                acc(1'b0, OFS_DATA, 1'b1, 16'hBEEF);
            if (rd[BIT_BUSY] === 1'b0)
                return;
        end
        check(rd[BIT_BUSY], 1'b0);
    endtask
    task automatic run_cmd(input logic [7:0] code);
        int s;
        s = starts;
        wr(OFS_LENGTH, 8'h01);
        wr(OFS_STATE, code);
        @(negedge clock);
        check(starts, s + 1);
        check(cmd_code, code);
        rdr(OFS_STATE);
        check(rd & 8'hD1, 8'h80);
        idle_wait();
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #400000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
    initial
    begin
        reset = 1'b1;
        bus = '{1'b1, 1'b1, 3'h0, 1'b1, 1'b1};
        data_in = 16'h0000;
        latency = 8'd40;
        fail_mode = 1'b0;
        fail_code = 8'h00;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rdr(OFS_LENGTH);
        check(rd, LENGTH_RESET);
        rdr(OFS_STATE);
        check(rd, STATE_RESET);
        rdr(OFS_UNIT);
        check(rd, UNIT_RESET);
        wr(OFS_SECTOR, 8'h12);
        wr(OFS_TRK_LO, 8'h34);
        wr(OFS_TRK_HI, 8'h56);
        wr(OFS_UNIT, 8'hE5);
        wr(OFS_FAULT, 8'h55);
        acc(1'b1, OFS_LEGACY, 1'b1, 16'h00FF);
        rdr(OFS_UNIT);
        check(rd, 8'hE5);
        rdr(OFS_TRK_HI);
        check(rd, 8'h56);
        acc(1'b1, OFS_LEGACY, 1'b0, 16'h0000);
        check(rd[5:2], 4'hA);
        wr(OFS_LENGTH, 8'h00);
        check(cmd_sectors, 9'h100);
        run_cmd(8'h30);
        check(cmd_lba, 28'h5563412);
        check(cmd_option, 8'h55);
        check(last_w, 16'hBEEF);
        check(card_interrupt_request_n, 1'b0);
        rdr(OFS_STATE);
        check(rd, 8'h50);
        check(card_interrupt_request_n, 1'b1);
        wr(OFS_STATE, 8'hFF);
        idle_wait();
        rdr(OFS_FAULT);
        check(rd, 8'h04);
        rdr(OFS_STATE);
        check(rd, 8'h51);
        fail_mode <= 1'b1;
        fail_code <= 8'hFF;
        wr(OFS_LENGTH, 8'h03);
        wr(OFS_STATE, 8'h20);
        idle_wait();
        rdr(OFS_LENGTH);
        check(rd, 8'h03);
        rdr(OFS_FAULT);
        check(rd, FAULT_MASK);
        fail_mode <= 1'b0;
        latency <= 8'd4;
        foreach (codes[i])
            run_cmd(codes[i]);
        wr(OFS_UNIT, 8'hB0);
        wr(OFS_STATE, 8'h20);
        @(negedge clock);
        check(starts, 1 + 1 + 27);
        wr(OFS_UNIT, 8'hA0);
        rdr(OFS_STATE);
        check(rd, 8'h50);
        acc(1'b1, OFS_SHADOW, 1'b1, 16'h0002);
        run_cmd(8'hE1);
        check(card_interrupt_request_n, 1'b1);
        acc(1'b1, OFS_SHADOW, 1'b1, 16'h0004);
        check(soft_reset, 1'b1);
        acc(1'b1, OFS_SHADOW, 1'b1, 16'h0000);
        summarize();
    end
endmodule // tfp_task_file_tb
`default_nettype wire

//--- logic/tfp_pkg.sv
// Purpose: Constants and types for the IDE task-file port.
// Assumes: Single 100 MHz clock, synchronous active-high reset.
// Notes: Offsets are the three low address lines.
`default_nettype none
package tfp_pkg;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_FAULT = 3'h1;
    localparam logic [2:0] OFS_LENGTH = 3'h2;
    localparam logic [2:0] OFS_SECTOR = 3'h3;
    localparam logic [2:0] OFS_TRK_LO = 3'h4;
    localparam logic [2:0] OFS_TRK_HI = 3'h5;
    localparam logic [2:0] OFS_UNIT = 3'h6;
    localparam logic [2:0] OFS_STATE = 3'h7;
    localparam logic [2:0] OFS_SHADOW = 3'h6;
    localparam logic [2:0] OFS_LEGACY = 3'h7;
    localparam logic [7:0] LENGTH_RESET = 8'h01;
    localparam logic [7:0] UNIT_RESET = 8'hA0;
    localparam logic [7:0] STATE_RESET = 8'h50;
    localparam int BIT_BUSY = 7;
    localparam int BIT_READY = 6;
    localparam int BIT_DSC = 4;
    localparam int BIT_DRQ = 3;
    localparam int BIT_ERR = 0;
    localparam int BIT_LBA = 6;
    localparam int BIT_UNIT = 4;
    localparam int BIT_ABORT = 2;
    localparam int BIT_IEN_N = 1;
    localparam int BIT_SRST = 2;
    localparam logic [7:0] FIXED_ONES = 8'hA0;
    localparam logic [7:0] FAULT_MASK = 8'hD5;
    localparam logic [8:0] SECTORS_FOR_ZERO = 9'h100;

    typedef enum logic [1:0] {
        TFP_IDLE = 2'b00,
        TFP_EXEC = 2'b01,
        TFP_XFER = 2'b10
    } tfp_mode_t;

    typedef struct packed {
        logic primary_select_n;
        logic secondary_select_n;
        logic [2:0] addr;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
    } tfp_bus_t;

    typedef struct packed {
        logic done;
        logic xfer;
        logic fail;
        logic [7:0] fault;
    } tfp_engine_t;

    typedef struct packed {
        tfp_mode_t mode;
        logic rd_q;
        logic wr_q;
        logic [15:0] data;
        logic [7:0] fault;
        logic [7:0] option;
        logic [7:0] length;
        logic [7:0] sector;
        logic [7:0] trk_lo;
        logic [7:0] trk_hi;
        logic [7:0] unit;
        logic [7:0] state;
        logic [7:0] opcode;
        logic [7:0] ctl;
        logic irq;
        logic cmd_pulse;
        logic rd_pulse;
        logic wr_pulse;
        logic [15:0] rdata;
    } tfp_state_t;
endpackage
`default_nettype wire

//--- logic/tfp_task_file.sv
// Purpose: Task-file register block of a storage card in true IDE mode.
// Assumes: Host strobes are synchronous to clock; the media engine is outside.
// Notes: Strobes act on their falling edge; data bus is three signals.
// Notes on behaviour
// - Secondary high, primary low: low address picks one of eight task-file locations.
// - Secondary low, primary high, 110/111: alternate status, control, drive address.
// - Sixteen-bit data port, word or byte access, decoded apart from the error location.
// - Error bits 7,6,4,2,0 report faults; bits 5,3,1 read zero.
// - Aborted bit is set when a command cannot run, e.g. invalid code.
// - Feature location is write-only and parameterises the next command.
// - A sector count of zero means 256 sectors for transfers.
// - Failed multi-sector transfer leaves remaining sectors in the count.
// - Sector count starts at one.
// - Sector and cylinder registers give the start address of the transfer.
// - Drive/head bits 7 and 5 are one; bit 6 picks LBA (cmd_lba is built the same either way); bits 3-0 head.
// - LBA is head, cylinder high, cylinder low, sector number from top to bottom.
// - Drive/head bit 4 selects the unit; the card's number is configured.
// - Status is read-only; other bits are invalid while busy is set.
// - Reading status negates the interrupt request.
// - Writing a command clears status bits 0, 4, 6 and sets busy.
// - Alternate status shows the same status but leaves the interrupt alone.
// - Power-management command codes are accepted in both encodings.
// - Listed transfer command codes are accepted.
// - Device control enables the interrupt and issues a soft reset.
// - Drive address bits 5-2 read the inverted head bits.
`default_nettype none
module tfp_task_file
    import tfp_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Host bus.
    input wire tfp_pkg::tfp_bus_t bus,
    input wire logic byte_mode,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic card_interrupt_request_n,
    // Configuration.
    input wire logic unit_number_config,
    // Media engine.
    input wire tfp_pkg::tfp_engine_t engine,
    input wire logic [15:0] engine_rdata,
    input wire logic engine_rvalid,
    output logic [7:0] cmd_code,
    output logic cmd_start,
    output logic [8:0] cmd_sectors,
    output logic [27:0] cmd_lba,
    output logic [7:0] cmd_option,
    output logic [15:0] host_wdata,
    output logic host_wvalid,
    output logic host_rtaken,
    output logic soft_reset
);
    import tfp_pkg::*;

    tfp_state_t s_q;
    tfp_state_t s_d;

    function automatic logic cmd_known(input logic [7:0] c);
        case (c)
            8'hE5, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'hE6, 8'h99,
            8'hE2, 8'h96, 8'hE0, 8'h94: cmd_known = 1'b1;
            8'h20, 8'h21, 8'hC4, 8'h22, 8'h23, 8'h40, 8'h41, 8'h30, 8'h31,
            8'hC5, 8'h38, 8'hCD, 8'h32, 8'h33, 8'h3C: cmd_known = 1'b1;
            8'hEF: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction

    function automatic logic cmd_moves_data(input logic [7:0] c);
        case (c)
            8'h20, 8'h21, 8'hC4, 8'h22, 8'h23, 8'h30, 8'h31, 8'hC5, 8'h38,
            8'hCD, 8'h32, 8'h33, 8'h3C: cmd_moves_data = 1'b1;
            default: cmd_moves_data = 1'b0;
        endcase
    endfunction

    logic pri_sel;
    logic sec_sel;
    logic rd_edge;
    logic wr_edge;
    logic selected;
    logic ctl_busy;
    assign pri_sel = bus.secondary_select_n && !bus.primary_select_n;
    assign sec_sel = !bus.secondary_select_n && bus.primary_select_n
        && bus.addr[2:1] == 2'b11;
    assign rd_edge = !bus.io_read_strobe_n && s_q.rd_q;
    assign wr_edge = !bus.io_write_strobe_n && s_q.wr_q;
    assign selected = s_q.unit[BIT_UNIT] == unit_number_config;
    assign ctl_busy = s_q.state[BIT_BUSY];

    always_comb
    begin
        s_d = s_q;
        s_d.rd_q = bus.io_read_strobe_n;
        s_d.wr_q = bus.io_write_strobe_n;
        s_d.cmd_pulse = 1'b0;
        s_d.rd_pulse = 1'b0;
        s_d.wr_pulse = 1'b0;
        if (engine_rvalid)
        begin
            s_d.data = engine_rdata;
        end
        if (rd_edge && pri_sel)
        begin
            case (bus.addr)
                OFS_DATA:
                begin
                    s_d.rdata = byte_mode ? {8'h00, s_q.data[7:0]} : s_q.data;
                    s_d.rd_pulse = s_q.mode == TFP_XFER;
                end
                OFS_FAULT: s_d.rdata = {8'h00, s_q.fault & FAULT_MASK};
                OFS_LENGTH: s_d.rdata = {8'h00, s_q.length};
                OFS_SECTOR: s_d.rdata = {8'h00, s_q.sector};
                OFS_TRK_LO: s_d.rdata = {8'h00, s_q.trk_lo};
                OFS_TRK_HI: s_d.rdata = {8'h00, s_q.trk_hi};
                OFS_UNIT: s_d.rdata = {8'h00, s_q.unit};
                OFS_STATE:
                begin
                    s_d.rdata = {8'h00, s_q.state};
                    s_d.irq = 1'b0;
                end
                default: s_d.rdata = 16'h0000;
            endcase
        end
        else if (rd_edge && sec_sel)
        begin
            if (bus.addr == OFS_SHADOW)
            begin
                s_d.rdata = {8'h00, s_q.state};
            end
            else
            begin
                s_d.rdata = {8'h00, 2'b00, ~s_q.unit[3:0], 2'b00};
            end
        end
        if (wr_edge && pri_sel)
        begin
            case (bus.addr)
                OFS_DATA:
                begin
                    s_d.data = data_in;
                    s_d.wr_pulse = s_q.mode == TFP_XFER;
                end
                OFS_FAULT: s_d.option = data_in[7:0];
                OFS_LENGTH: s_d.length = data_in[7:0];
                OFS_SECTOR: s_d.sector = data_in[7:0];
                OFS_TRK_LO: s_d.trk_lo = data_in[7:0];
                OFS_TRK_HI: s_d.trk_hi = data_in[7:0];
                OFS_UNIT: s_d.unit = data_in[7:0] | FIXED_ONES;
                OFS_STATE:
                begin
                    if (selected && s_q.mode == TFP_IDLE)
                    begin
                        s_d.opcode = data_in[7:0];
                        s_d.state[BIT_ERR] = 1'b0;
                        s_d.state[BIT_DSC] = 1'b0;
                        s_d.state[BIT_READY] = 1'b0;
                        s_d.state[BIT_BUSY] = 1'b1;
                        s_d.fault = 8'h00;
                        s_d.mode = TFP_EXEC;
                        s_d.cmd_pulse = cmd_known(data_in[7:0]);
                    end
                end
                default: s_d.rdata = s_q.rdata;
            endcase
        end
        else if (wr_edge && sec_sel && bus.addr == OFS_SHADOW)
        begin
            s_d.ctl = data_in[7:0];
        end
        case (s_q.mode)
            TFP_IDLE: s_d.mode = s_d.mode;
            TFP_EXEC:
            begin
                if (!cmd_known(s_q.opcode))
                begin
                    s_d.fault[BIT_ABORT] = 1'b1;
                    s_d.state = STATE_RESET | 8'h01;
                    s_d.irq = 1'b1;
                    s_d.mode = TFP_IDLE;
                end
                else if (engine.xfer && cmd_moves_data(s_q.opcode))
                begin
                    s_d.state[BIT_DRQ] = 1'b1;
                    s_d.mode = TFP_XFER;
                end
                else if (engine.done)
                begin
                    s_d.fault = engine.fault & FAULT_MASK;
                    s_d.state = STATE_RESET | {7'h00, engine.fail};
                    s_d.irq = 1'b1;
                    s_d.mode = TFP_IDLE;
                end
            end
            TFP_XFER:
            begin
                if (engine.done)
                begin
                    if (!engine.fail)
                    begin
                        s_d.length = s_q.length - 8'h01;
                    end
                    s_d.fault = engine.fault & FAULT_MASK;
                    s_d.state = engine.fail ? (STATE_RESET | 8'h01) : STATE_RESET;
                    s_d.irq = 1'b1;
                    s_d.mode = engine.fail ? TFP_IDLE : TFP_EXEC;
                    if (!engine.fail && s_q.length == 8'h01)
                    begin
                        s_d.mode = TFP_IDLE;
                    end
                    else if (!engine.fail)
                    begin
                        s_d.state[BIT_BUSY] = 1'b1;
                        s_d.state[BIT_READY] = 1'b0;
                    end
                end
            end
            default: s_d.mode = TFP_IDLE;
        endcase
        if (s_q.ctl[BIT_SRST])
        begin
            s_d.mode = TFP_IDLE;
            s_d.state = STATE_RESET;
            s_d.fault = 8'h00;
            s_d.length = LENGTH_RESET;
            s_d.irq = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.mode <= TFP_IDLE;
            s_q.rd_q <= 1'b1;
            s_q.wr_q <= 1'b1;
            s_q.length <= LENGTH_RESET;
            s_q.unit <= UNIT_RESET;
            s_q.state <= STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign data_out = s_q.rdata;
    assign data_oe = !bus.io_read_strobe_n && (pri_sel || sec_sel)
        && (selected || sec_sel);
    assign card_interrupt_request_n = !(s_q.irq && !s_q.ctl[BIT_IEN_N]);
    assign cmd_code = s_q.opcode;
    assign cmd_start = s_q.cmd_pulse;
    assign cmd_sectors = (s_q.length == 8'h00) ? SECTORS_FOR_ZERO
        : {1'b0, s_q.length};
    assign cmd_lba = s_q.unit[BIT_LBA] ? {s_q.unit[3:0], s_q.trk_hi, s_q.trk_lo, s_q.sector}
        : {s_q.unit[3:0], s_q.trk_hi, s_q.trk_lo, s_q.sector};
    assign cmd_option = s_q.option;
    assign host_wdata = s_q.data;
    assign host_wvalid = s_q.wr_pulse;
    assign host_rtaken = s_q.rd_pulse;
    assign soft_reset = s_q.ctl[BIT_SRST];

    a_cmd_sets_busy: assert property (@(posedge clock) disable iff (reset)
        (wr_edge && pri_sel && bus.addr == OFS_STATE && selected && s_q.mode == TFP_IDLE)
        |=> (s_q.state[BIT_BUSY] && !s_q.state[BIT_READY]))
        else $error("busy not set after command write");
    a_status_read_irq: assert property (@(posedge clock) disable iff (reset)
        (rd_edge && pri_sel && bus.addr == OFS_STATE && !s_q.ctl[BIT_SRST]
        && s_q.mode == TFP_IDLE) |=> !s_q.irq)
        else $error("status read left interrupt pending");
    a_shadow_keep_irq: assert property (@(posedge clock) disable iff (reset)
        (rd_edge && sec_sel && s_q.irq && s_q.mode == TFP_IDLE && !s_q.ctl[BIT_SRST])
        |=> s_q.irq)
        else $error("alternate status read cleared interrupt");
    a_zero_count: assert property (@(posedge clock) disable iff (reset)
        (s_q.length == 8'h00) |-> (cmd_sectors == 9'h100))
        else $error("zero count not 256 sectors");
    a_fault_zero_bits: assert property (@(posedge clock) disable iff (reset)
        (s_q.fault & ~FAULT_MASK) == 8'h00)
        else $error("reserved error bits set");
    a_unit_fixed_ones: assert property (@(posedge clock) disable iff (reset)
        s_q.unit[7] && s_q.unit[5])
        else $error("drive head fixed bits not one");
    a_bad_cmd_abort: assert property (@(posedge clock) disable iff (reset)
        (s_q.mode == TFP_EXEC && !cmd_known(s_q.opcode) && !s_q.ctl[BIT_SRST])
        |=> (s_q.fault[BIT_ABORT] && s_q.state[BIT_ERR]))
        else $error("invalid command not aborted");
    a_lba_order: assert property (@(posedge clock) disable iff (reset)
        cmd_lba[7:0] == s_q.sector && cmd_lba[27:24] == s_q.unit[3:0])
        else $error("block address order wrong");
    a_fail_keeps_count: assert property (@(posedge clock) disable iff (reset)
        (s_q.mode == TFP_XFER && engine.done && engine.fail && !s_q.ctl[BIT_SRST])
        |=> $stable(s_q.length))
        else $error("failed transfer changed count");
    c_cmd_write: cover property (@(posedge clock) disable iff (reset) s_q.cmd_pulse);
    c_xfer_mode: cover property (@(posedge clock) disable iff (reset) s_q.mode == TFP_XFER);
    c_abort_seen: cover property (@(posedge clock) disable iff (reset) s_q.fault[BIT_ABORT]);
endmodule // tfp_task_file
`default_nettype wire
